/* inc/cct_params.svh */
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CCT_OFS_FLAGS 8'h00
`define CCT_OFS_MODE 8'h04
`define CCT_OFS_UCNT 8'h08
`define CCT_OFS_LCNT 8'h0C
`define CCT_OFS_UCMP 8'h10
`define CCT_OFS_LCMP 8'h14

// ****************************************
// flags and clear control fields
// ****************************************
`define CCT_BIT_HOVF 7
`define CCT_BIT_HCMF 6
`define CCT_BIT_HOVIE 5
`define CCT_BIT_HCCLR 4
`define CCT_BIT_LOVF 3
`define CCT_BIT_LCMF 2
`define CCT_BIT_LOVIE 1
`define CCT_BIT_LCCLR 0

// ****************************************
// mode control fields
// ****************************************
`define CCT_BIT_ULEVEL 7
`define CCT_BIT_SPLIT 6
`define CCT_BIT_LLEVEL 3

// ****************************************
// clock select codes and reset values
// ****************************************
`define CCT_SEL_DIV32 3'h4
`define CCT_SEL_DIV16 3'h5
`define CCT_SEL_DIV4 3'h6
`define CCT_SEL_SLOW 3'h7
`define CCT_DIV_W 7
`define CCT_RST_REG 8'h00
`define CCT_RST_CMP 8'hFF
`define CCT_MAX8 8'hFF
`define CCT_MAX16 16'hFFFF

`endif

/* inc/cct_pkg.sv */
package cct_pkg;
    typedef logic [7:0] cct_byte_t;
    typedef logic [15:0] cct_word_t;
    typedef logic [2:0] cct_sel_t;
    typedef logic [3:0] cct_flags_t;
endpackage

/* core/cct_timer_status.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "cct_params.svh"

// Operation
// - upper rollover sets high overflow flag
// - flag clears by 0 after read 1
// - writing 1 to flags does nothing
// - upper match sets high match flag
// - bit 5 gates high overflow request
// - 16-bit mode clears whole counter
// - 8-bit mode clears upper counter only
// - lower rollover sets low overflow flag
// - lower match sets low match flag
// - bit 1 gates low overflow request
// - bit 0 clears lower on match
// - counter increments per selected clock pulse
// - compare on each count tick; clear, request, toggle
// - two independent 8-bit timers supported
// - mode bit selects 16 or 8-bit
// - 16-bit rollover sets high overflow flag
// - toggle outputs start at level, invert
// - overflow request needs local and controller enable; match request needs controller enable only
module cct_timer_status
    import cct_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic event_in,
    input wire logic event_rise_sel,
    input wire logic upper_irq_ctrl_enable,
    input wire logic lower_irq_ctrl_enable,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic upper_toggle_out,
    output logic lower_toggle_out,
    output logic high_irq,
    output logic low_irq
);

    // ****************************************
    // state
    // ****************************************
    cct_flags_t flags_ff, armed_ff;
    logic high_overflow_irq_enable_ff, high_clear_on_match_ff;
    logic low_overflow_irq_enable_ff, low_clear_on_match_ff;
    cct_byte_t timer_mode_ctrl_ff;
    cct_byte_t upper_counter_ff, lower_counter_ff;
    cct_byte_t upper_compare_value_ff, lower_compare_value_ff;
    logic [`CCT_DIV_W-1:0] div_ff;
    logic ev_s1_ff, ev_s2_ff, ev_s3_ff;

    // ****************************************
    // bus decode
    // ****************************************
    logic setup, acc, hit;
    logic wr_flags, rd_flags, wr_mode, wr_ucnt, wr_lcnt, wr_ucmp, wr_lcmp;
    cct_byte_t timer_flags_and_clear_ctrl, nxt_rdata;

    assign setup = psel & ~penable;
    assign acc = psel & penable & pready;
    assign wr_flags = acc & pwrite & (paddr == `CCT_OFS_FLAGS);
    assign rd_flags = acc & ~pwrite & (paddr == `CCT_OFS_FLAGS);
    assign wr_mode = acc & pwrite & (paddr == `CCT_OFS_MODE);
    assign wr_ucnt = acc & pwrite & (paddr == `CCT_OFS_UCNT);
    assign wr_lcnt = acc & pwrite & (paddr == `CCT_OFS_LCNT);
    assign wr_ucmp = acc & pwrite & (paddr == `CCT_OFS_UCMP);
    assign wr_lcmp = acc & pwrite & (paddr == `CCT_OFS_LCMP);

    assign timer_flags_and_clear_ctrl = {flags_ff[3], flags_ff[2], high_overflow_irq_enable_ff,
        high_clear_on_match_ff, flags_ff[1], flags_ff[0], low_overflow_irq_enable_ff,
        low_clear_on_match_ff};

    always_comb begin
        hit = 1'b1;
        case (paddr)
            `CCT_OFS_FLAGS: nxt_rdata = timer_flags_and_clear_ctrl;
            `CCT_OFS_MODE: nxt_rdata = timer_mode_ctrl_ff;
            `CCT_OFS_UCNT: nxt_rdata = upper_counter_ff;
            `CCT_OFS_LCNT: nxt_rdata = lower_counter_ff;
            `CCT_OFS_UCMP: nxt_rdata = upper_compare_value_ff;
            `CCT_OFS_LCMP: nxt_rdata = lower_compare_value_ff;
            default: begin
                nxt_rdata = `CCT_RST_REG;
                hit = 1'b0;
            end
        endcase
    end

    // one wait-free answer: data is latched in setup, pready rises for the access cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= {24'h00_0000, nxt_rdata};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // count sources
    // ****************************************
    logic split_mode_select, ev_edge, tick_h, tick_l;

    assign split_mode_select = timer_mode_ctrl_ff[`CCT_BIT_SPLIT];

    function automatic logic sel_tick(input cct_sel_t s, input logic ext,
                                      input logic [`CCT_DIV_W-1:0] d);
        case (s)
            `CCT_SEL_DIV32: sel_tick = &d[4:0];
            `CCT_SEL_DIV16: sel_tick = &d[3:0];
            `CCT_SEL_DIV4: sel_tick = &d[1:0];
            `CCT_SEL_SLOW: sel_tick = &d;
            default: sel_tick = ext;
        endcase
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // event pin is asynchronous, so it passes two stages before edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ev_s1_ff <= 1'b0;
            ev_s2_ff <= 1'b0;
            ev_s3_ff <= 1'b0;
        end else begin
            ev_s1_ff <= event_in;
            ev_s2_ff <= ev_s1_ff;
            ev_s3_ff <= ev_s2_ff;
        end
    end

    assign ev_edge = event_rise_sel ? (ev_s2_ff & ~ev_s3_ff) : (~ev_s2_ff & ev_s3_ff);
    assign tick_l = sel_tick(timer_mode_ctrl_ff[2:0], ev_edge, div_ff);
    assign tick_h = split_mode_select & sel_tick(timer_mode_ctrl_ff[6:4], 1'b0, div_ff);

    // ****************************************
    // compare, clear, overflow
    // ****************************************
    cct_word_t full_counter, full_compare_value;
    logic lo_match, hi16_match, hi8_match, hi_match;
    logic lo_clr, full_clr, hi_clr, lo_ovf, hi_ovf, carry;

    assign full_counter = {upper_counter_ff, lower_counter_ff};
    assign full_compare_value = {upper_compare_value_ff, lower_compare_value_ff};
    // a compare write in the same cycle voids that match
    assign lo_match = tick_l & (lower_counter_ff == lower_compare_value_ff) & ~wr_lcmp
        & ~wr_lcnt;
    assign hi16_match = ~split_mode_select & tick_l & (full_counter == full_compare_value)
        & ~wr_ucmp & ~wr_lcmp & ~wr_lcnt & ~wr_ucnt;
    assign hi8_match = tick_h & (upper_counter_ff == upper_compare_value_ff) & ~wr_ucmp
        & ~wr_ucnt;
    assign hi_match = hi16_match | hi8_match;
    assign lo_clr = lo_match & low_clear_on_match_ff;
    assign full_clr = hi16_match & high_clear_on_match_ff;
    assign hi_clr = hi8_match & high_clear_on_match_ff;
    // a counter write in the same cycle swallows the overflow
    assign lo_ovf = tick_l & (lower_counter_ff == `CCT_MAX8) & ~lo_clr & ~full_clr & ~wr_lcnt;
    assign carry = ~split_mode_select & tick_l & (lower_counter_ff == `CCT_MAX8) & ~lo_clr
        & ~full_clr;
    assign hi_ovf = split_mode_select
        ? (tick_h & (upper_counter_ff == `CCT_MAX8) & ~hi_clr & ~wr_ucnt)
        : (carry & (full_counter == `CCT_MAX16) & ~wr_ucnt & ~wr_lcnt);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lower_counter_ff <= `CCT_RST_REG;
        end else if (wr_lcnt) begin
            lower_counter_ff <= pwdata[7:0];
        end else if (lo_clr | full_clr) begin
            lower_counter_ff <= `CCT_RST_REG;
        end else if (tick_l) begin
            lower_counter_ff <= lower_counter_ff + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upper_counter_ff <= `CCT_RST_REG;
        end else if (wr_ucnt) begin
            upper_counter_ff <= pwdata[7:0];
        end else if (full_clr | hi_clr) begin
            upper_counter_ff <= `CCT_RST_REG;
        end else if (split_mode_select ? tick_h : carry) begin
            upper_counter_ff <= upper_counter_ff + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upper_compare_value_ff <= `CCT_RST_CMP;
            lower_compare_value_ff <= `CCT_RST_CMP;
            timer_mode_ctrl_ff <= `CCT_RST_REG;
        end else begin
            if (wr_ucmp) begin
                upper_compare_value_ff <= pwdata[7:0];
            end
            if (wr_lcmp) begin
                lower_compare_value_ff <= pwdata[7:0];
            end
            if (wr_mode) begin
                timer_mode_ctrl_ff <= pwdata[7:0];
            end
        end
    end

    // ****************************************
    // flags, enables, outputs
    // ****************************************
    cct_flags_t set_ev, clr_ev;
    localparam int FLAG_POS [4] = '{`CCT_BIT_HOVF, `CCT_BIT_HCMF, `CCT_BIT_LOVF, `CCT_BIT_LCMF};

    assign set_ev = {hi_ovf, hi_match, lo_ovf, lo_match};

    generate
        for (genvar gi = 0; gi < 4; gi++) begin : g_flag
            // only a 0 after a read of 1 clears; written 1s are ignored
            assign clr_ev[gi] = wr_flags & ~pwdata[FLAG_POS[3-gi]] & armed_ff[gi];
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flags_ff[gi] <= 1'b0;
                    armed_ff[gi] <= 1'b0;
                end else begin
                    flags_ff[gi] <= set_ev[gi] | (flags_ff[gi] & ~clr_ev[gi]);
                    if (wr_flags) begin
                        armed_ff[gi] <= 1'b0;
                    end else if (rd_flags & prdata[FLAG_POS[3-gi]]) begin
                        armed_ff[gi] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_overflow_irq_enable_ff <= 1'b0;
            high_clear_on_match_ff <= 1'b0;
            low_overflow_irq_enable_ff <= 1'b0;
            low_clear_on_match_ff <= 1'b0;
        end else if (wr_flags) begin
            high_overflow_irq_enable_ff <= pwdata[`CCT_BIT_HOVIE];
            high_clear_on_match_ff <= pwdata[`CCT_BIT_HCCLR];
            low_overflow_irq_enable_ff <= pwdata[`CCT_BIT_LOVIE];
            low_clear_on_match_ff <= pwdata[`CCT_BIT_LCCLR];
        end
    end

    // a mode write reloads the level, winning over a same-cycle toggle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upper_toggle_out <= 1'b0;
            lower_toggle_out <= 1'b0;
        end else begin
            if (wr_mode) begin
                upper_toggle_out <= pwdata[`CCT_BIT_ULEVEL];
            end else if (hi_match) begin
                upper_toggle_out <= ~upper_toggle_out;
            end
            if (wr_mode) begin
                lower_toggle_out <= pwdata[`CCT_BIT_LLEVEL];
            end else if (lo_match) begin
                lower_toggle_out <= ~lower_toggle_out;
            end
        end
    end

    // requests are levels that follow the sticky flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            high_irq <= 1'b0;
            low_irq <= 1'b0;
        end else begin
            high_irq <= upper_irq_ctrl_enable & ((flags_ff[3] & high_overflow_irq_enable_ff)
                | flags_ff[2]);
            low_irq <= lower_irq_ctrl_enable & ((flags_ff[1] & low_overflow_irq_enable_ff)
                | flags_ff[0]);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_HOVF_SET: assert property (@(posedge clk) disable iff (!reset_n)
        hi_ovf |=> flags_ff[3]) else $error("high overflow flag not set");
    AST_LOVF_SET: assert property (@(posedge clk) disable iff (!reset_n)
        lo_ovf |=> flags_ff[1]) else $error("low overflow flag not set");
    AST_NO_CLR_UNREAD: assert property (@(posedge clk) disable iff (!reset_n)
        (flags_ff[0] && !armed_ff[0] && !set_ev[0]) |=> flags_ff[0])
        else $error("match flag cleared without prior read");
    AST_ONE_NO_EFFECT: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_flags && pwdata[`CCT_BIT_LCMF] && !flags_ff[0] && !set_ev[0]) |=> !flags_ff[0])
        else $error("writing one set a flag");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
        (clr_ev[2] && set_ev[2]) |=> flags_ff[2]) else $error("set lost to clear");
    AST_FULL_CLR: assert property (@(posedge clk) disable iff (!reset_n)
        (full_clr && !wr_lcnt && !wr_ucnt) |=> (upper_counter_ff == 8'h00
        && lower_counter_ff == 8'h00)) else $error("16-bit clear missed");
    AST_HI8_CLR: assert property (@(posedge clk) disable iff (!reset_n)
        hi_clr |=> upper_counter_ff == 8'h00) else $error("upper 8-bit clear missed");
    AST_LOW_INC: assert property (@(posedge clk) disable iff (!reset_n)
        (tick_l && !wr_lcnt && !lo_clr && !full_clr)
        |=> lower_counter_ff == $past(lower_counter_ff) + 8'h01)
        else $error("lower counter did not advance");
    AST_HI_IRQ_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        (!upper_irq_ctrl_enable || !high_overflow_irq_enable_ff) && !flags_ff[2]
        |=> !high_irq) else $error("high request not gated");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n)
        (lo_match && !wr_mode) |=> lower_toggle_out != $past(lower_toggle_out))
        else $error("lower toggle missed");
    AST_SPLIT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (split_mode_select && !tick_h && !wr_ucnt) |=> $stable(upper_counter_ff))
        else $error("upper counter moved without its own tick");

endmodule

/* testbench/cct_timer_status_tb.sv */
`timescale 1ns/1ps
`include "cct_params.svh"
module cct_timer_status_tb;
    import cct_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, event_in, event_rise_sel;
    logic upper_irq_ctrl_enable, lower_irq_ctrl_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, upper_toggle_out, lower_toggle_out, high_irq, low_irq, err;
    int fails, cmp_count, n;
    cct_byte_t d;
    logic [7:0] a;

    cct_timer_status DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .event_in(event_in),
        .event_rise_sel(event_rise_sel), .upper_irq_ctrl_enable(upper_irq_ctrl_enable),
        .lower_irq_ctrl_enable(lower_irq_ctrl_enable), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .upper_toggle_out(upper_toggle_out),
        .lower_toggle_out(lower_toggle_out), .high_irq(high_irq), .low_irq(low_irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // expectations
    // ****************************************
    // only the enable and clear-select bits survive a write of ones
    function automatic logic [31:0] ctrl_only(input cct_byte_t v);
        return {24'h000000, v & 8'h33};
    endfunction

    function automatic logic [31:0] bit_of(input logic [31:0] v, input int b);
        return {31'h00000000, v[b]};
    endfunction

    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // master holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fails++;
            finish_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input cct_byte_t v);
        apb(1'b1, ad, {24'h000000, v});
    endtask

    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h00000000);
    endtask

    // a slow tick source means a flag may take many reads to appear
    task automatic wait_flag(input int b);
        int k;
        k = 0;
        do begin
            rd(`CCT_OFS_FLAGS);
            k++;
        end while (q[b] !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            fails++;
            finish_test();
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fails = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        event_in = 1'b0;
        event_rise_sel = 1'b1;
        upper_irq_ctrl_enable = 1'b1;
        lower_irq_ctrl_enable = 1'b1;
        void'($urandom(32'h3AC057F7));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`CCT_OFS_FLAGS);
        check(q, 32'h00000000);
        rd(`CCT_OFS_UCMP);
        check(q, 32'h000000FF);
        rd(8'h18);
        check({31'h00000000, err}, 32'h00000001);
        wr(`CCT_OFS_FLAGS, 8'hFF);
        rd(`CCT_OFS_FLAGS);
        check(q, ctrl_only(8'hFF));
        // counters stand still with event select and a quiet pin
        wr(`CCT_OFS_MODE, 8'h00);
        for (int i = 0; i < 24; i++) begin
            a = 8'h04 * (2 + $urandom_range(0, 3));
            d = $urandom;
            if (i % 6 == 0) begin
                a = `CCT_OFS_FLAGS;
            end
            wr(a, d);
            rd(a);
            check(q, (a == `CCT_OFS_FLAGS) ? ctrl_only(d) : {24'h000000, d});
        end
        // event counting on the chosen edge
        wr(`CCT_OFS_FLAGS, 8'h00);
        wr(`CCT_OFS_LCNT, 8'h00);
        n = $urandom_range(1, 20);
        event_rise_sel <= $urandom;
        repeat (n) begin
            @(posedge clk) event_in <= 1'b1;
            repeat (4) @(posedge clk);
            event_in <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (5) @(posedge clk);
        rd(`CCT_OFS_LCNT);
        check(q, n);
        // lower rollover in 16-bit mode carries into upper
        wr(`CCT_OFS_LCMP, 8'h80);
        wr(`CCT_OFS_UCNT, 8'h00);
        wr(`CCT_OFS_LCNT, 8'hFC);
        wr(`CCT_OFS_MODE, 8'h06);
        wait_flag(`CCT_BIT_LOVF);
        check(bit_of(q, `CCT_BIT_HOVF), 32'h00000000);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_UCNT);
        check(q, 32'h00000001);
        wr(`CCT_OFS_FLAGS, 8'h0A);
        repeat (2) @(posedge clk);
        check({31'h00000000, low_irq}, 32'h00000001);
        wr(`CCT_OFS_FLAGS, 8'h08);
        repeat (2) @(posedge clk);
        check({31'h00000000, low_irq}, 32'h00000000);
        wr(`CCT_OFS_FLAGS, 8'h00);
        rd(`CCT_OFS_FLAGS);
        check(bit_of(q, `CCT_BIT_LOVF), 32'h00000001);
        wr(`CCT_OFS_FLAGS, 8'h00);
        rd(`CCT_OFS_FLAGS);
        check(bit_of(q, `CCT_BIT_LOVF), 32'h00000000);
        // upper alone in 8-bit mode, lower held still
        wr(`CCT_OFS_UCMP, 8'h80);
        wr(`CCT_OFS_UCNT, 8'hFE);
        wr(`CCT_OFS_LCNT, 8'h55);
        wr(`CCT_OFS_FLAGS, 8'h20);
        wr(`CCT_OFS_MODE, 8'h60);
        wait_flag(`CCT_BIT_HOVF);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_LCNT);
        check(q, 32'h00000055);
        check({31'h00000000, high_irq}, 32'h00000001);
        upper_irq_ctrl_enable <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h00000000, high_irq}, 32'h00000000);
        upper_irq_ctrl_enable <= 1'b1;
        rd(`CCT_OFS_FLAGS);
        check(bit_of(q, `CCT_BIT_HOVF), 32'h00000001);
        wr(`CCT_OFS_FLAGS, 8'h00);
        // upper match in 8-bit mode clears the upper half alone
        wr(`CCT_OFS_UCMP, 8'h03);
        wr(`CCT_OFS_UCNT, 8'h00);
        wr(`CCT_OFS_FLAGS, 8'h10);
        wr(`CCT_OFS_MODE, 8'h60);
        wait_flag(`CCT_BIT_HCMF);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_UCNT);
        check({31'h00000000, q < 32'h03}, 32'h00000001);
        rd(`CCT_OFS_LCNT);
        check(q, 32'h00000055);
        wr(`CCT_OFS_FLAGS, 8'h00);
        // lower match clears lower and toggles its pin
        wr(`CCT_OFS_MODE, 8'h88);
        repeat (2) @(posedge clk);
        check({31'h00000000, lower_toggle_out}, 32'h00000001);
        check({31'h00000000, upper_toggle_out}, 32'h00000001);
        wr(`CCT_OFS_LCMP, 8'h10);
        wr(`CCT_OFS_LCNT, 8'h0D);
        wr(`CCT_OFS_FLAGS, 8'h01);
        wr(`CCT_OFS_MODE, 8'h0E);
        wait_flag(`CCT_BIT_LCMF);
        check({31'h00000000, lower_toggle_out}, 32'h00000000);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_LCNT);
        check({31'h00000000, q < 32'h10}, 32'h00000001);
        // full 16-bit match clears the whole counter
        wr(`CCT_OFS_FLAGS, 8'h10);
        wr(`CCT_OFS_UCMP, 8'h01);
        wr(`CCT_OFS_LCMP, 8'h02);
        wr(`CCT_OFS_UCNT, 8'h01);
        wr(`CCT_OFS_LCNT, 8'h00);
        wr(`CCT_OFS_MODE, 8'h06);
        wait_flag(`CCT_BIT_HCMF);
        check({31'h00000000, upper_toggle_out}, 32'h00000001);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_UCNT);
        check(q, 32'h00000000);
        rd(`CCT_OFS_LCNT);
        check({31'h00000000, q < 32'h08}, 32'h00000001);
        // full rollover sets the high overflow flag
        wr(`CCT_OFS_FLAGS, 8'h00);
        wr(`CCT_OFS_UCMP, 8'h80);
        wr(`CCT_OFS_UCNT, 8'hFF);
        wr(`CCT_OFS_LCNT, 8'hFC);
        wr(`CCT_OFS_MODE, 8'h06);
        wait_flag(`CCT_BIT_HOVF);
        wr(`CCT_OFS_MODE, 8'h00);
        rd(`CCT_OFS_UCNT);
        check(q, 32'h00000000);
        // a clear that meets a fresh match leaves both match flags set
        event_rise_sel <= 1'b1;
        wr(`CCT_OFS_FLAGS, 8'h00);
        wr(`CCT_OFS_UCMP, 8'h21);
        wr(`CCT_OFS_LCMP, 8'h43);
        wr(`CCT_OFS_UCNT, 8'h21);
        wr(`CCT_OFS_LCNT, 8'h43);
        event_in <= 1'b1;
        repeat (6) @(posedge clk);
        event_in <= 1'b0;
        rd(`CCT_OFS_FLAGS);
        check(bit_of(q, `CCT_BIT_HCMF), 32'h00000001);
        check(bit_of(q, `CCT_BIT_LCMF), 32'h00000001);
        wr(`CCT_OFS_LCNT, 8'h43);
        // the pin edge reaches the counter three edges later, with the write access
        event_in <= 1'b1;
        wr(`CCT_OFS_FLAGS, 8'h00);
        rd(`CCT_OFS_FLAGS);
        check(bit_of(q, `CCT_BIT_HCMF), 32'h00000001);
        check(bit_of(q, `CCT_BIT_LCMF), 32'h00000001);
        finish_test();
    end
endmodule
